// ### core/lbc_controller.sv
// LIN bus controller setup: mode, baud chain, checksum and serializer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RL1] Frames are serialized in hardware as start, eight data bits, stop.
// [RL2] Mode and autobaud sit in the direct mode register, others indirect.
// [RL3] The data register reaches the register chosen by the address one.
// [RL4] Bit 6 of the mode register picks master or slave operation.
// [RL5] Bit 5 picks autobaud, which only takes effect in slave mode.
// [RL6] Bit time is two to prescaler plus one, times divider, times mult+1.
// [RL7] Prescaler 0-3, multiplier 0-31, divider 200-511 are supported.
// [RL8] Classic and enhanced checksums are computed in hardware.
// [RL9] Bit 0x80 of the frame size register at 0x0B selects enhanced.
// [RL10] Mode register value 0x80 enables and 0x40 makes a master.
// [RL11] Divider low is at index 0x0C, prescaler and multiplier at 0x0D.
// [RL12] Frame control is at 0x08 and writing 0x0C clears error and irq.
// [RL13] The system supplies a core clock of at least 8 MHz.
// [RL14] Index 0x0D holds prescaler 7:6, multiplier 5:1 and divider bit 8.
// [RL15] Slave autobaud measures the master bit time in the sync field.
module lbc_controller
   import lbc_pkg::*;
#(
   parameter int unsigned REARM = REARM_CYCLES
) (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic [1:0] i_reg_sel,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_wdata,
   output var  logic [7:0] o_rdata,
   input  wire logic       i_tx_valid,
   input  wire logic       i_tx_first,
   input  wire logic [7:0] i_tx_data,
   output var  logic       o_tx_ready,
   output var  logic       o_lin_tx,
   input  wire logic       i_lin_rx,
   output var  logic       o_irq,
   output var  logic       o_err,
   output var  logic [7:0] o_checksum
);

   lbc_state_s  s_q;
   lbc_state_s  s_d;
   lbc_txw_s    head;
   logic        use_auto;
   logic        enabled;
   logic [1:0]  pre;
   logic [4:0]  mul;
   logic [8:0]  div_raw;
   logic [8:0]  div_eff;
   logic [17:0] period_man;
   logic [17:0] period;
   logic        can_run;
   logic        push;
   logic        pop;
   logic        wr_ind;
   logic        irq_set;
   logic        err_set;
   logic        rx_fall;
   logic [8:0]  add9;
   logic [7:0]  nsum;

   // Baud factors, autobaud selection and the resulting bit period.
   always_comb begin
      enabled    = s_q.cf[CF_ENABLE];                          // [RL10]
      use_auto   = s_q.cf[CF_AUTOSEL] & ~s_q.cf[CF_MASTER];    // [RL4] [RL5]
      pre        = s_q.pm[PM_PRE_HI:PM_PRE_LO];                // [RL14]
      mul        = s_q.pm[PM_MUL_HI:PM_MUL_LO];                // [RL14]
      div_raw    = {s_q.pm[PM_DIV8], s_q.divl};                // [RL14]
      div_eff    = (div_raw < DIV_MIN) ? DIV_MIN : div_raw;    // [RL7]
      period_man = 18'((18'(div_eff) << (3'(pre) + 3'h1))
                       * (18'(mul) + 18'h00001));              // [RL6]
      period     = use_auto ? s_q.ab_period : period_man;      // [RL15]
      can_run    = enabled & (~use_auto | s_q.ab_valid);
      head       = s_q.buf_w[s_q.rd_ptr];
      push       = i_tx_valid & s_q.ready;
      pop        = (s_q.ser == LBC_IDLE) & can_run & (s_q.cnt != 2'h0);
      wr_ind     = i_wr & (i_reg_sel == SEL_DATA);
      rx_fall    = s_q.rx_prev & ~i_lin_rx;
   end

   // Running checksum: ID seeds it only when enhanced, carry wraps around.
   always_comb begin
      add9 = {1'b0, s_q.sum} + {1'b0, head.data};
      if (head.first) begin
         nsum = s_q.size[SIZE_ENH] ? head.data : 8'h00;        // [RL8] [RL9]
      end else begin
         nsum = add9[7:0] + {7'h00, add9[8]};                  // [RL8]
      end
   end

   // Next state of registers, buffer, serializer and autobaud.
   always_comb begin
      s_d     = s_q;
      irq_set = 1'b0;
      err_set = 1'b0;
      s_d.tick    = 1'b0;
      s_d.rx_prev = i_lin_rx;

      // Register writes, direct and through the indirect pair.
      if (i_wr && i_reg_sel == SEL_MODE) begin
         s_d.cf = i_wdata;                                     // [RL2] [RL10]
      end
      if (i_wr && i_reg_sel == SEL_ADDR) begin
         s_d.adr = i_wdata;                                    // [RL2]
      end
      if (wr_ind) begin
         case (s_q.adr)                                        // [RL3]
            IDX_CTRL: s_d.ctrl = i_wdata & ~CTRL_SELFC;        // [RL12]
            IDX_SIZE: s_d.size = i_wdata;                      // [RL9]
            IDX_DIVL: s_d.divl = i_wdata;                      // [RL11]
            IDX_MUL:  s_d.pm   = i_wdata;                      // [RL11]
            default:  s_d.size = s_q.size;
         endcase
      end

      // Register reads return one cycle after the strobe.
      if (i_rd) begin
         case (i_reg_sel)
            SEL_MODE: s_d.rdata = s_q.cf;                      // [RL2]
            SEL_ADDR: s_d.rdata = s_q.adr;
            SEL_DATA: begin
               case (s_q.adr)                                  // [RL3]
                  IDX_CTRL: s_d.rdata = {s_q.ctrl[7:4], s_q.irq,
                                         s_q.err, s_q.ctrl[1:0]};
                  IDX_SIZE: s_d.rdata = s_q.size;
                  IDX_DIVL: s_d.rdata = s_q.divl;
                  IDX_MUL:  s_d.rdata = s_q.pm;
                  default:  s_d.rdata = 8'h00;
               endcase
            end
            default:  s_d.rdata = 8'h00;
         endcase
      end

      // Two-entry buffer between the byte source and the serializer.
      if (push) begin
         s_d.buf_w[s_q.wr_ptr] = {i_tx_first, i_tx_data};
         s_d.wr_ptr = ~s_q.wr_ptr;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      s_d.cnt   = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
      s_d.ready = (s_d.cnt != 2'h2);

      // Bit timer runs only while a byte is on the line.
      if (s_q.ser != LBC_IDLE) begin
         if (s_q.bitcnt >= period - 18'h00001) begin           // [RL6]
            s_d.bitcnt = 18'h00000;
            s_d.tick   = 1'b1;
         end else begin
            s_d.bitcnt = s_q.bitcnt + 18'h00001;
         end
      end

      // Byte serializer, least significant bit first.
      case (s_q.ser)
         LBC_IDLE: begin
            s_d.txd = 1'b1;
            if (pop) begin
               s_d.shreg  = head.data;
               s_d.sum    = nsum;                              // [RL8]
               s_d.chk    = ~nsum;                             // [RL8]
               // Counts from one: the timer idles in this cycle, so the
               // start bit would otherwise run one cycle too long.
               s_d.bitcnt = 18'h00001;                         // [RL6]
               s_d.ser    = LBC_START;
               s_d.txd    = 1'b0;                              // [RL1]
            end
         end
         LBC_START: begin
            if (s_q.tick) begin
               s_d.txd   = s_q.shreg[0];                       // [RL1]
               s_d.shreg = {1'b0, s_q.shreg[7:1]};
               s_d.bitn  = 3'h0;
               s_d.ser   = LBC_DATA;
            end
         end
         LBC_DATA: begin
            if (s_q.tick) begin
               if (s_q.bitn == 3'h7) begin
                  s_d.txd = 1'b1;                              // [RL1]
                  s_d.ser = LBC_STOP;
               end else begin
                  s_d.txd   = s_q.shreg[0];
                  s_d.shreg = {1'b0, s_q.shreg[7:1]};
                  s_d.bitn  = s_q.bitn + 3'h1;
               end
            end
         end
         LBC_STOP: begin
            if (s_q.tick) begin
               s_d.ser = LBC_IDLE;
               irq_set = (s_q.cnt == 2'h0);
            end
         end
         default: begin
            s_d.ser = LBC_IDLE;
            s_d.txd = 1'b1;
         end
      endcase

      // A disabled interface drops the byte on the line, keeps the buffered bytes and idles the line high.
      if (!enabled) begin
         s_d.ser = LBC_IDLE;                                   // [RL10]
         s_d.txd = 1'b1;
      end

      // Autobaud: time five falling edges of the sync field, eight bits.
      if (use_auto && enabled) begin
         if (s_q.ab_edges != 3'h0) begin
            s_d.ab_cnt = s_q.ab_cnt + 18'h00001;
         end
         if (rx_fall) begin
            s_d.ab_idle = 18'h00000;
         end else if (i_lin_rx) begin
            s_d.ab_idle = s_q.ab_idle + 18'h00001;
         end
         if (!s_q.ab_valid && rx_fall) begin
            if (s_q.ab_edges == 3'h0) begin
               // The cycle of this edge already belongs to the sync bits.
               s_d.ab_cnt   = 18'h00001;                       // [RL15]
               s_d.ab_edges = 3'h1;
            end else if (s_q.ab_edges == AB_LAST_EDGE - 3'h1) begin
               s_d.ab_edges  = 3'h0;
               s_d.ab_period = s_q.ab_cnt >> AB_SHIFT;         // [RL15]
               s_d.ab_valid  = ((s_q.ab_cnt >> AB_SHIFT) >= AB_MIN_PERIOD);
               err_set       = ~s_d.ab_valid;
            end else begin
               s_d.ab_edges = s_q.ab_edges + 3'h1;
            end
         end
         if (s_q.ab_idle >= 18'(REARM - 1) && s_q.ser == LBC_IDLE) begin
            s_d.ab_valid = 1'b0;                               // [RL15]
            s_d.ab_edges = 3'h0;
            s_d.ab_idle  = 18'h00000;
         end
      end else begin
         s_d.ab_valid = 1'b0;
         s_d.ab_edges = 3'h0;
         s_d.ab_idle  = 18'h00000;
      end

      // Sticky flags: a clear by write loses against a set in that cycle.
      if (wr_ind && s_q.adr == IDX_CTRL && i_wdata[CTRL_RSTINT]) begin
         s_d.irq = 1'b0;                                       // [RL12]
      end
      if (wr_ind && s_q.adr == IDX_CTRL && i_wdata[CTRL_RSTERR]) begin
         s_d.err = 1'b0;                                       // [RL12]
      end
      if (irq_set || err_set) begin
         s_d.irq = 1'b1;
      end
      if (err_set) begin
         s_d.err = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q        <= '0;
         s_q.cf     <= RST_REG8;
         s_q.ready  <= 1'b1;
         s_q.txd    <= 1'b1;
         s_q.chk    <= 8'hff;
         s_q.ser    <= LBC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   always_comb begin
      o_rdata    = s_q.rdata;
      o_tx_ready = s_q.ready;
      o_lin_tx   = s_q.txd;
      o_irq      = s_q.irq;
      o_err      = s_q.err;
      o_checksum = s_q.chk;
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   // Register access, flag clear, checksum seeds, bit timing and autobaud.
   chk_mode_read: assert property (                            // [RL2]
      i_rd && i_reg_sel == SEL_MODE |=> o_rdata == $past(s_q.cf))
      else $error("mode register read wrong");
   chk_indirect_read: assert property (                        // [RL3]
      i_rd && i_reg_sel == SEL_DATA && s_q.adr == IDX_DIVL && !i_wr
      |=> o_rdata == $past(s_q.divl))
      else $error("indirect read wrong");
   chk_irq_clear: assert property (                            // [RL12]
      wr_ind && s_q.adr == IDX_CTRL && i_wdata == CTRL_SELFC
      && !irq_set && !err_set |=> !o_irq && !o_err)
      else $error("flags not cleared");
   chk_enh_seed: assert property (                             // [RL9]
      pop && head.first && s_q.size[SIZE_ENH]
      |=> o_checksum == ~$past(head.data))
      else $error("enhanced checksum not seeded by id");
   chk_classic_seed: assert property (                         // [RL8]
      pop && head.first && !s_q.size[SIZE_ENH] |=> o_checksum == 8'hff)
      else $error("classic checksum includes id");
   chk_bit_period: assert property (                           // [RL6]
      s_q.tick && !use_auto && s_q.ser == LBC_DATA && $stable(s_q.pm)
      && $stable(s_q.divl) |-> $past(s_q.bitcnt) == period_man - 18'h00001)
      else $error("bit period wrong");
   chk_div_range: assert property (div_eff >= DIV_MIN)         // [RL7]
      else $error("divider below range");
   chk_master_manual: assert property (                        // [RL5]
      s_q.cf[CF_MASTER] |-> !use_auto)
      else $error("autobaud used in master mode");
   chk_disable_idle: assert property (                         // [RL10]
      !enabled |=> s_q.ser == LBC_IDLE && o_lin_tx)
      else $error("disabled interface not idle");
   chk_start_low: assert property (                            // [RL1]
      s_q.ser == LBC_IDLE && pop |=> !o_lin_tx [*2])
      else $error("start bit not low");
   chk_ab_period: assert property (                            // [RL15]
      $rose(s_q.ab_valid) |-> s_q.ab_period == ($past(s_q.ab_cnt) >> 3))
      else $error("autobaud period wrong");
   chk_size_write: assert property (                           // [RL9]
      wr_ind && s_q.adr == IDX_SIZE |=> s_q.size == $past(i_wdata))
      else $error("frame size register write lost");
   chk_pm_write: assert property (                             // [RL11]
      wr_ind && s_q.adr == IDX_MUL |=> s_q.pm == $past(i_wdata))
      else $error("prescale register write lost");
   chk_ab_reject: assert property (                            // [RL15]
      $rose(o_err) |-> !s_q.ab_valid && o_irq)
      else $error("autobaud error without both flags");

   cov_frame_done: cover property (s_q.ser == LBC_STOP ##1 $rose(o_irq));
   cov_ab_lock:    cover property ($rose(s_q.ab_valid));
   cov_buf_full:   cover property (!o_tx_ready && i_tx_valid);
   cov_irq_clear:  cover property ($fell(o_irq));
   cov_ab_error:   cover property ($rose(o_err));

endmodule // lbc_controller

`default_nettype wire

// ### core/lbc_pkg.sv
// Package with constants and types of the LIN bus controller setup block.
`default_nettype none

package lbc_pkg;

   // Core clock rate and the least rate the controller may run from.
   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned MIN_CORE_MHZ  = 8;

   // Idle time on the receive line after which autobaud rearms.
   localparam int unsigned REARM_TIME_US = 2000;
   localparam int unsigned REARM_CYCLES  = REARM_TIME_US * CLK_MHZ;

   // Selection of the directly addressed registers.
   localparam logic [1:0] SEL_MODE = 2'h0;
   localparam logic [1:0] SEL_ADDR = 2'h1;
   localparam logic [1:0] SEL_DATA = 2'h2;

   // Indices of the indirectly reached registers.
   localparam logic [7:0] IDX_CTRL = 8'h08;
   localparam logic [7:0] IDX_SIZE = 8'h0b;
   localparam logic [7:0] IDX_DIVL = 8'h0c;
   localparam logic [7:0] IDX_MUL  = 8'h0d;

   // Field positions.
   localparam int CF_ENABLE   = 7;
   localparam int CF_MASTER   = 6;
   localparam int CF_AUTOSEL  = 5;
   localparam int SIZE_ENH    = 7;
   localparam int PM_PRE_HI   = 7;
   localparam int PM_PRE_LO   = 6;
   localparam int PM_MUL_HI   = 5;
   localparam int PM_MUL_LO   = 1;
   localparam int PM_DIV8     = 0;
   localparam int CTRL_RSTINT = 3;
   localparam int CTRL_RSTERR = 2;

   // Reset values and masks.
   localparam logic [7:0] RST_REG8   = 8'h00;
   localparam logic [7:0] CTRL_SELFC = 8'h0c;

   // Baud limits and autobaud measurement constants.
   localparam logic [8:0]  DIV_MIN       = 9'h0c8;
   localparam logic [2:0]  AB_LAST_EDGE  = 3'h5;
   localparam int          AB_SHIFT      = 3;
   localparam logic [17:0] AB_MIN_PERIOD = 18'h00190;

   // Serializer states, Gray coded along the frame.
   typedef enum logic [1:0] {
      LBC_IDLE  = 2'b00,
      LBC_START = 2'b01,
      LBC_DATA  = 2'b11,
      LBC_STOP  = 2'b10
   } lbc_ser_e;

   // One buffered byte and whether it opens a frame (identifier).
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } lbc_txw_s;

   // Complete state of the controller.
   typedef struct packed {
      logic [7:0]     cf;
      logic [7:0]     adr;
      logic [7:0]     ctrl;
      logic [7:0]     size;
      logic [7:0]     divl;
      logic [7:0]     pm;
      logic [7:0]     rdata;
      logic           irq;
      logic           err;
      lbc_txw_s [1:0] buf_w;
      logic           wr_ptr;
      logic           rd_ptr;
      logic [1:0]     cnt;
      logic           ready;
      lbc_ser_e       ser;
      logic [7:0]     shreg;
      logic [2:0]     bitn;
      logic [17:0]    bitcnt;
      logic           tick;
      logic           txd;
      logic [7:0]     sum;
      logic [7:0]     chk;
      logic [2:0]     ab_edges;
      logic [17:0]    ab_cnt;
      logic [17:0]    ab_period;
      logic           ab_valid;
      logic [17:0]    ab_idle;
      logic           rx_prev;
   } lbc_state_s;

endpackage

`default_nettype wire

// ### test/lbc_lin_node.sv
// Far-side LIN node model: byte receiver and sync field sender.
`timescale 1ns/1ps
`default_nettype none
module lbc_lin_node (
   input  wire logic i_clock,
   input  wire logic i_lin,
   output var  logic o_rx
);
   int         per = 400;
   int         start_len;
   logic [7:0] rxq[$];
   logic [7:0] b;

   // The bus idles recessive through its pull-up.
   initial o_rx = 1'b1;

   // Times each start bit and samples the data bits at mid-bit.
   initial begin
      forever begin
         @(negedge i_clock iff i_lin === 1'b0);
         start_len = 0;
         while (i_lin === 1'b0) begin
            start_len++;
            @(negedge i_clock);
         end
         repeat (per / 2) @(negedge i_clock);
         for (int i = 0; i < 8; i++) begin
            b[i] = i_lin;
            repeat (per) @(negedge i_clock);
         end
         rxq.push_back(b);
      end
   end

   // Sends start bit and 0x55 at bit period p; the stop level is left high.
   task automatic sync(input int p);
      logic [9:0] f;
      f = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 9; i++) begin
         o_rx = f[i];
         repeat (p) @(posedge i_clock);
         #1;
      end
      o_rx = 1'b1;
   endtask
endmodule // lbc_lin_node
`default_nettype wire

// ### test/lbc_controller_tb_top.sv
// Self-checking bench of the LIN bus controller setup block.
`timescale 1ns/1ps
`default_nettype none
module lbc_controller_tb_top import lbc_pkg::*;;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wd = 8'h00;
   logic        tv = 1'b0;
   logic        tf = 1'b0;
   logic [7:0]  td = 8'h00;
   logic [7:0]  rdata, cks, v, acc;
   logic        rdy, line, rx, irq, err, enh, full;
   logic [31:0] seed = 32'h01e8;
   logic [7:0]  ix[4] = '{IDX_CTRL, IDX_SIZE, IDX_DIVL, IDX_MUL};
   logic [7:0]  expq[$];
   int          failures = 0;
   int          compares = 0;

   // Clock at 50 MHz, above the least core clock.
   always #10 clk = ~clk;

   // Rearm time stays above the longest sync bit, so a lock can finish.
   lbc_controller #(.REARM(1000)) dut (
      .i_clock(clk), .i_resetn(rstn), .i_reg_sel(sel), .i_wr(wr),
      .i_rd(rd), .i_wdata(wd), .o_rdata(rdata), .i_tx_valid(tv),
      .i_tx_first(tf), .i_tx_data(td), .o_tx_ready(rdy),
      .o_lin_tx(line), .i_lin_rx(rx), .o_irq(irq), .o_err(err),
      .o_checksum(cks));

   lbc_lin_node node (.i_clock(clk), .i_lin(line), .o_rx(rx));

   // Random bytes from a fixed-seed shift register.
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   // Checksum addition with the carry wrapped back in.
   function automatic logic [7:0] cadd(input logic [7:0] a, b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   // Bit time in cycles from the prescale/multiply and divider bytes.
   function automatic int period(input logic [7:0] pm, dl);
      int d;
      d = {pm[0], dl};
      return (d << (pm[7:6] + 1)) * (pm[5:1] + 1);
   endfunction

   // Byte and flag compare, then count compare.
   task automatic chk8(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chki(input string n, input int e, g);
      compares++;
      if (g != e) begin
         failures++;
         $display("wrong value %s exp %0d got %0d", n, e, g);
      end
   endtask

   // One strobe cycle, then one quiet cycle so strobes never re-rise at once.
   task automatic bus(input logic [1:0] s, input logic w, input logic [7:0] d);
      sel = s;
      wr = w;
      rd = !w;
      wd = d;
      @(posedge clk);
      #1 wr = 1'b0;
      rd = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wri(input logic [7:0] a, d);
      bus(SEL_ADDR, 1'b1, a);
      bus(SEL_DATA, 1'b1, d);
   endtask
   task automatic rdi(input logic [7:0] a, e);
      bus(SEL_ADDR, 1'b1, a);
      bus(SEL_DATA, 1'b0, 8'h00);
      chk8("indirect register", e, rdata);
   endtask

   // Offers n odd bytes back to back and tracks the expected checksum.
   task automatic tx(input int n, input logic first);
      int k;
      for (int i = 0; i < n; i++) begin
         td = rnd() | 8'h01;
         tf = first && i == 0;
         tv = 1'b1;
         k = 0;
         while (rdy !== 1'b1 && k < 99999) begin
            full = 1'b1;
            @(posedge clk);
            #1 k++;
         end
         @(posedge clk);
         #1 acc = tf ? (enh ? td : 8'h00) : cadd(acc, td);
         expq.push_back(td);
      end
      tv = 1'b0;
   endtask

   // Waits for the end of a frame and checks what the far node saw.
   task automatic frame(input int p);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 60000) begin
         @(posedge clk);
         #1 k++;
      end
      chk8("frame irq", 8'h01, {7'h00, irq});
      chk8("checksum", ~acc, cks);
      chki("start bit cycles", p, node.start_len);
      chki("byte count", expq.size(), node.rxq.size());
      while (expq.size() > 0) begin
         chk8("rx byte", expq.pop_front(), node.rxq.pop_front());
      end
      wri(IDX_CTRL, CTRL_SELFC);
      chk8("irq cleared", 8'h00, {6'h00, irq, err});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Cuts a hang short well past the expected run time.
   initial begin
      #(20 * 95000);
      failures++;
      final_report();
   end

   // Main sequence: registers, manual frames, then slave autobaud.
   initial begin
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      chk8("reset pins", 8'h0c, {4'h0, line, rdy, irq, err});
      chk8("reset checksum", 8'hff, cks);
      bus(SEL_MODE, 1'b0, 8'h00);
      chk8("mode reg", 8'h00, rdata);
      for (int i = 0; i < 4; i++) rdi(ix[i], 8'h00);
      for (int i = 1; i < 4; i++) begin
         v = rnd();
         wri(ix[i], v);
         rdi(ix[i], v);
      end
      wri(8'h0a, 8'h5a);
      rdi(8'h0a, 8'h00);
      bus(2'h3, 1'b1, 8'hff);
      bus(2'h3, 1'b0, 8'h00);
      chk8("unmapped select", 8'h00, rdata);
      wri(IDX_CTRL, 8'hff);
      rdi(IDX_CTRL, 8'hf3);
      wri(IDX_CTRL, 8'h00);
      // Enhanced frame at the smallest divider, offered while disabled.
      wri(IDX_DIVL, 8'hc8);
      wri(IDX_MUL, 8'h00);
      wri(IDX_SIZE, 8'h80);
      enh = 1'b1;
      node.per = period(8'h00, 8'hc8);
      tx(1, 1'b1);
      repeat (60) @(posedge clk);
      #1;
      chk8("line while off", 8'h01, {7'h00, line});
      bus(SEL_MODE, 1'b1, 8'he0);
      bus(SEL_MODE, 1'b0, 8'h00);
      chk8("mode reg", 8'he0, rdata);
      full = 1'b0;
      tx(3, 1'b0);
      chk8("buffer refused", 8'h01, {7'h00, full});
      frame(node.per);
      // Classic frame with divider bit 8, prescale 1 and multiply 1.
      wri(IDX_SIZE, 8'h00);
      enh = 1'b0;
      wri(IDX_MUL, 8'h43);
      wri(IDX_DIVL, 8'h00);
      node.per = period(8'h43, 8'h00);
      tx(2, 1'b1);
      frame(node.per);
      // Slave autobaud: a too-fast sync is an error, then a lock.
      bus(SEL_MODE, 1'b1, 8'ha0);
      node.sync(300);
      repeat (20) @(posedge clk);
      #1;
      chk8("autobaud error", 8'h03, {6'h00, irq, err});
      rdi(IDX_CTRL, 8'h0c);
      wri(IDX_CTRL, CTRL_SELFC);
      repeat (250) @(posedge clk);
      #1;
      node.per = 480;
      tx(1, 1'b1);
      repeat (20) @(posedge clk);
      #1;
      chk8("line before lock", 8'h01, {7'h00, line});
      node.sync(480);
      frame(480);
      final_report();
   end
endmodule // lbc_controller_tb_top
`default_nettype wire
